// [rtl/mrpd_dram.sv]
// memory device end: fifth and sixth mode registers, parity check, status bits
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module mrpd_dram (
	input wire logic clk,
	input wire logic reset,
	mrpd_if.dram bus,
	input wire mrpd_pkg::mrpd_org_e org,
	input wire logic mpr_read,
	input wire logic crc_fail,
	output logic cmd_exec,
	output logic cmd_dropped,
	output logic par_err,
	output logic crc_err,
	output logic rd_inv_on,
	output logic wr_inv_on,
	output logic wr_mask_on,
	output logic nom_term_on,
	output logic [2:0] park_term_code,
	output logic [3:0] cas_spacing,
	output logic vref_cal_en,
	output logic vref_range,
	output logic [5:0] vref_level
);
	import mrpd_pkg::*;

	logic [12:0] mr5_r;
	logic [17:0] mr6_r;
	logic perr_r;
	logic crcerr_r;

	logic [MRPD_PIPE_DEPTH-1:0] pv_r;
	logic [MRPD_PIPE_DEPTH-1:0] pbad_r;
	logic [MRPD_PIPE_DEPTH-1:0] pmrs_r;
	logic [1:0] pbg_r [MRPD_PIPE_DEPTH];
	logic [1:0] pba_r [MRPD_PIPE_DEPTH];
	logic [17:0] pa_r [MRPD_PIPE_DEPTH];

	logic [2:0] lat_code;
	logic lat_ok;
	logic [2:0] tap;
	logic is_cmd;
	logic is_mrs;
	logic chk_on;
	logic mismatch;
	logic perr_set;
	logic exe;
	logic exe_mrs;
	logic [2:0] exe_sel;
	logic wr5;
	logic wr6;
	logic [17:0] exe_a;
	logic wide_org;

	assign lat_code = mr5_r[MRPD_MR5_LAT_LO +: 3];
	// reserved latency codes leave parity off rather than guess a delay
	assign lat_ok = (lat_code != MRPD_LAT_OFF) && (lat_code <= MRPD_LAT_MAX);

	// a command needs cs low with cke high; cke low is power-down
	assign is_cmd = !bus.cs_n && bus.cke;
	assign is_mrs = is_cmd && bus.act_n && !bus.a[16] && !bus.a[15] && !bus.a[14];

	// the sticky bit gates checking unless persistent mode is set
	assign chk_on = lat_ok && (mr5_r[MRPD_MR5_PERSIST] || !perr_r);
	assign mismatch = mrpd_parity(bus.act_n, bus.bg, bus.ba, bus.a) != bus.par;
	assign perr_set = is_cmd && chk_on && mismatch;

	// with parity on, a command leaves the pipe after the programmed latency
	assign tap = lat_ok ? 3'(lat_code + MRPD_LAT_TAP_OFS) : 3'h0;
	assign exe = pv_r[tap] && !pbad_r[tap];
	assign exe_mrs = exe && pmrs_r[tap];
	assign exe_a = pa_r[tap];
	assign exe_sel = {pbg_r[tap][0], pba_r[tap]};
	// bank group bit 1 carries register bit 21, which must be zero
	assign wr5 = exe_mrs && (exe_sel == MRPD_SEL_MR5) && !pbg_r[tap][1];
	assign wr6 = exe_mrs && (exe_sel == MRPD_SEL_MR6) && !pbg_r[tap][1];

	assign wide_org = (org == MRPD_ORG_X8) || (org == MRPD_ORG_X16);

	// command pipe; a fifth register write restarts it, else the executing write
	// would reach the new, deeper tap and run twice; spaced commands lose nothing
	always_ff @(posedge clk) begin
		if (reset) begin
			pv_r <= '0;
			pbad_r <= '0;
			pmrs_r <= '0;
		end else if (wr5) begin
			pv_r <= MRPD_PIPE_DEPTH'(is_cmd);
			pbad_r <= MRPD_PIPE_DEPTH'(perr_set);
			pmrs_r <= MRPD_PIPE_DEPTH'(is_mrs);
		end else begin
			pv_r <= {pv_r[MRPD_PIPE_DEPTH-2:0], is_cmd};
			pbad_r <= {pbad_r[MRPD_PIPE_DEPTH-2:0], perr_set};
			pmrs_r <= {pmrs_r[MRPD_PIPE_DEPTH-2:0], is_mrs};
		end
	end

	always_ff @(posedge clk) begin
		pbg_r[0] <= bus.bg;
		pba_r[0] <= bus.ba;
		pa_r[0] <= bus.a;
		for (int i = 1; i < MRPD_PIPE_DEPTH; i++) begin
			pbg_r[i] <= pbg_r[i-1];
			pba_r[i] <= pba_r[i-1];
			pa_r[i] <= pa_r[i-1];
		end
	end

	// fifth register, status bits kept apart
	always_ff @(posedge clk) begin
		if (reset) begin
			mr5_r <= MRPD_MR5_RST;
		end else if (wr5) begin
			mr5_r <= exe_a[12:0];
		end
	end

	// sticky parity status: a new error beats a clearing write
	always_ff @(posedge clk) begin
		if (reset) begin
			perr_r <= 1'b0;
		end else if (perr_set) begin
			perr_r <= 1'b1;
		end else if (wr5 && !exe_a[MRPD_MR5_PERR]) begin
			perr_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			crcerr_r <= 1'b0;
		end else if (crc_fail) begin
			crcerr_r <= 1'b1;
		end else if (wr5 && !exe_a[MRPD_MR5_CRCERR]) begin
			crcerr_r <= 1'b0;
		end
	end

	// sixth register holds A17..A0; reserved bits stored as written
	always_ff @(posedge clk) begin
		if (reset) begin
			mr6_r <= MRPD_MR6_RST;
		end else if (wr6) begin
			mr6_r <= exe_a;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cmd_exec <= 1'b0;
			cmd_dropped <= 1'b0;
		end else begin
			cmd_exec <= exe;
			cmd_dropped <= pv_r[tap] && pbad_r[tap];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			par_err <= 1'b0;
			crc_err <= 1'b0;
		end else begin
			par_err <= perr_r;
			crc_err <= crcerr_r;
		end
	end

	// one shared pin: inversion and masking exist only on wide parts
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_inv_on <= 1'b0;
			wr_inv_on <= 1'b0;
			wr_mask_on <= 1'b0;
		end else begin
			rd_inv_on <= wide_org && mr5_r[MRPD_MR5_RD_INV] && !mpr_read;
			wr_inv_on <= wide_org && mr5_r[MRPD_MR5_WR_INV];
			wr_mask_on <= wide_org && mr5_r[MRPD_MR5_MASK];
		end
	end

	// with the buffer off in power-down the pin may float, so it is not read
	always_ff @(posedge clk) begin
		if (reset) begin
			nom_term_on <= 1'b0;
			park_term_code <= 3'h0;
		end else begin
			nom_term_on <= bus.odt && !(!bus.cke && mr5_r[MRPD_MR5_ODT_OFF]);
			park_term_code <= mr5_r[MRPD_MR5_PARK_LO +: 3];
		end
	end

	// reserved spacing codes are passed on as the largest legal spacing
	always_ff @(posedge clk) begin
		if (reset) begin
			cas_spacing <= MRPD_CCD_BASE;
		end else if (mr6_r[MRPD_MR6_CCD_LO +: 3] > MRPD_CCD_MAX) begin
			cas_spacing <= 4'(MRPD_CCD_BASE + {1'b0, MRPD_CCD_MAX});
		end else begin
			cas_spacing <= 4'(MRPD_CCD_BASE + {1'b0, mr6_r[MRPD_MR6_CCD_LO +: 3]});
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			vref_cal_en <= 1'b0;
			vref_range <= 1'b0;
			vref_level <= 6'h00;
		end else begin
			vref_cal_en <= mr6_r[MRPD_MR6_VREF_EN];
			vref_range <= mr6_r[MRPD_MR6_VREF_RANGE];
			vref_level <= mr6_r[MRPD_MR6_VREF_LO +: 6];
		end
	end

endmodule : mrpd_dram

// [shared/mrpd_pkg.sv]
// constants, types and parity function shared by both ends of the mode register link
package mrpd_pkg;

	typedef enum logic [1:0] {
		MRPD_ORG_X4 = 2'b00,
		MRPD_ORG_X8 = 2'b01,
		MRPD_ORG_X16 = 2'b10
	} mrpd_org_e;

	localparam logic [2:0] MRPD_SEL_MR5 = 3'h5;
	localparam logic [2:0] MRPD_SEL_MR6 = 3'h6;

	localparam int MRPD_MR5_RD_INV = 12;
	localparam int MRPD_MR5_WR_INV = 11;
	localparam int MRPD_MR5_MASK = 10;
	localparam int MRPD_MR5_PERSIST = 9;
	localparam int MRPD_MR5_PARK_LO = 6;
	localparam int MRPD_MR5_ODT_OFF = 5;
	localparam int MRPD_MR5_PERR = 4;
	localparam int MRPD_MR5_CRCERR = 3;
	localparam int MRPD_MR5_LAT_LO = 0;
	localparam logic [12:0] MRPD_MR5_RST = 13'h0000;

	localparam logic [2:0] MRPD_LAT_OFF = 3'h0;
	localparam logic [2:0] MRPD_LAT_MAX = 3'h3;
	// latency code n gives n+3 clocks; the pipe tap is one less
	localparam logic [2:0] MRPD_LAT_TAP_OFS = 3'h2;
	localparam int MRPD_PIPE_DEPTH = 6;

	localparam int MRPD_MR6_CCD_LO = 10;
	localparam logic [2:0] MRPD_CCD_MAX = 3'h4;
	localparam logic [3:0] MRPD_CCD_BASE = 4'h4;
	localparam int MRPD_MR6_VREF_EN = 7;
	localparam int MRPD_MR6_VREF_RANGE = 6;
	localparam int MRPD_MR6_VREF_LO = 0;
	localparam logic [17:0] MRPD_MR6_RSVD = 18'h22300;
	localparam logic [17:0] MRPD_MR6_RST = 18'h00000;

	localparam logic [7:0] MRPD_REG_MR5 = 8'h00;
	localparam logic [7:0] MRPD_REG_MR6 = 8'h04;
	localparam logic [7:0] MRPD_REG_CTRL = 8'h08;
	localparam logic [7:0] MRPD_REG_STAT = 8'h0c;
	localparam int MRPD_CTRL_GO5 = 0;
	localparam int MRPD_CTRL_GO6 = 1;
	localparam int MRPD_CTRL_BADPAR = 2;
	localparam int MRPD_CTRL_PD = 3;
	localparam int MRPD_CTRL_ODT = 4;
	localparam int MRPD_STAT_REFUSED = 1;
	localparam logic [3:0] MRPD_GAP_CYCLES = 4'h8;

	typedef enum logic [1:0] {
		MRPD_ST_IDLE = 2'b00,
		MRPD_ST_DRIVE = 2'b01,
		MRPD_ST_GAP = 2'b10
	} mrpd_state_e;

	// even parity over activate, bank group, bank and all address lines
	function automatic logic mrpd_parity(input logic act_n, input logic [1:0] bg,
			input logic [1:0] ba, input logic [17:0] a);
		return ^{act_n, bg, ba, a};
	endfunction : mrpd_parity

endpackage : mrpd_pkg

// [shared/mrpd_if.sv]
// command and address pins between controller and memory device
`timescale 1ns/1ps
interface mrpd_if;
	logic cs_n;
	logic act_n;
	logic cke;
	logic odt;
	logic par;
	logic [1:0] bg;
	logic [1:0] ba;
	// a[16:14] double as the row, column and write strobes
	logic [17:0] a;

	modport dram (input cs_n, input act_n, input cke, input odt, input par,
		input bg, input ba, input a);
	modport ctrl (output cs_n, output act_n, output cke, output odt, output par,
		output bg, output ba, output a);
endinterface : mrpd_if

// [rtl/mrpd_ctrl.sv]
// controller end: shadows of the fifth and sixth registers, mode register writes
`timescale 1ns/1ps
module mrpd_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic stacked_die_variant,
	mrpd_if.ctrl bus
);
	import mrpd_pkg::*;

	mrpd_state_e state_r;
	logic [12:0] mr5_r;
	logic [17:0] mr6_r;
	logic pend5_r;
	logic pend6_r;
	logic badpar_r;
	logic pd_r;
	logic odt_r;
	logic refused_r;
	logic [3:0] gap_r;
	logic take;
	logic take5;
	logic wr5_ok;
	logic wr6_ok;
	logic [12:0] mr5_w;
	logic [2:0] sel;
	logic [17:0] a_nxt;

	assign take = (state_r == MRPD_ST_IDLE) && (pend5_r || pend6_r);
	assign take5 = pend5_r;
	// write inversion and masking never together; reserved latency refused
	assign wr5_ok = !(reg_wdata[MRPD_MR5_WR_INV] && reg_wdata[MRPD_MR5_MASK])
		&& (reg_wdata[MRPD_MR5_LAT_LO +: 3] <= MRPD_LAT_MAX);
	assign wr6_ok = reg_wdata[MRPD_MR6_CCD_LO +: 3] <= MRPD_CCD_MAX;
	assign mr5_w = stacked_die_variant ?
		(reg_wdata[12:0] & ~13'h1800) : reg_wdata[12:0];
	assign sel = take5 ? MRPD_SEL_MR5 : MRPD_SEL_MR6;
	assign a_nxt = take5 ? {5'h00, mr5_r} : (mr6_r & ~MRPD_MR6_RSVD);

	always_ff @(posedge clk) begin
		if (reset) begin
			mr5_r <= MRPD_MR5_RST;
			mr6_r <= MRPD_MR6_RST;
		end else if (reg_wr && reg_addr == MRPD_REG_MR5 && wr5_ok) begin
			mr5_r <= mr5_w;
		end else if (reg_wr && reg_addr == MRPD_REG_MR6 && wr6_ok) begin
			mr6_r <= reg_wdata[17:0];
		end
	end

	// a new go beats the take of an older one
	always_ff @(posedge clk) begin
		if (reset) begin
			pend5_r <= 1'b0;
			pend6_r <= 1'b0;
			badpar_r <= 1'b0;
			pd_r <= 1'b0;
			odt_r <= 1'b0;
		end else begin
			pend5_r <= (pend5_r && !(take && take5))
				|| (reg_wr && reg_addr == MRPD_REG_CTRL && reg_wdata[MRPD_CTRL_GO5]);
			pend6_r <= (pend6_r && !(take && !take5))
				|| (reg_wr && reg_addr == MRPD_REG_CTRL && reg_wdata[MRPD_CTRL_GO6]);
			if (reg_wr && reg_addr == MRPD_REG_CTRL) begin
				badpar_r <= reg_wdata[MRPD_CTRL_BADPAR];
				pd_r <= reg_wdata[MRPD_CTRL_PD];
				odt_r <= reg_wdata[MRPD_CTRL_ODT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			refused_r <= 1'b0;
		end else if ((reg_wr && reg_addr == MRPD_REG_MR5 && !wr5_ok)
				|| (reg_wr && reg_addr == MRPD_REG_MR6 && !wr6_ok)) begin
			refused_r <= 1'b1;
		end else if (reg_wr && reg_addr == MRPD_REG_STAT && reg_wdata[MRPD_STAT_REFUSED]) begin
			refused_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= MRPD_ST_IDLE;
			gap_r <= 4'h0;
		end else begin
			case (state_r)
				MRPD_ST_IDLE: begin
					if (take) begin
						state_r <= MRPD_ST_DRIVE;
					end
				end
				MRPD_ST_DRIVE: begin
					state_r <= MRPD_ST_GAP;
					gap_r <= 4'(MRPD_GAP_CYCLES - 4'h1);
				end
				MRPD_ST_GAP: begin
					if (gap_r == 4'h0) begin
						state_r <= MRPD_ST_IDLE;
					end else begin
						gap_r <= 4'(gap_r - 4'h1);
					end
				end
				default: begin
					state_r <= MRPD_ST_IDLE;
				end
			endcase
		end
	end

	// pins are registered; a mode write occupies exactly the drive state
	always_ff @(posedge clk) begin
		if (reset) begin
			bus.cs_n <= 1'b1;
			bus.act_n <= 1'b1;
			bus.bg <= 2'h0;
			bus.ba <= 2'h0;
			bus.a <= 18'h1c000;
			bus.par <= 1'b0;
		end else if (take) begin
			bus.cs_n <= 1'b0;
			bus.act_n <= 1'b1;
			bus.bg <= {1'b0, sel[2]};
			bus.ba <= sel[1:0];
			bus.a <= a_nxt;
			bus.par <= mrpd_parity(1'b1, {1'b0, sel[2]}, sel[1:0], a_nxt) ^ badpar_r;
		end else begin
			bus.cs_n <= 1'b1;
			bus.act_n <= 1'b1;
			bus.bg <= 2'h0;
			bus.ba <= 2'h0;
			bus.a <= 18'h1c000;
			bus.par <= 1'b0;
		end
	end

	// odt is always driven from a register, so it is valid in power-down
	always_ff @(posedge clk) begin
		if (reset) begin
			bus.cke <= 1'b1;
			bus.odt <= 1'b0;
		end else begin
			bus.cke <= !pd_r;
			bus.odt <= odt_r;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				MRPD_REG_MR5: reg_rdata <= {19'h0, mr5_r};
				MRPD_REG_MR6: reg_rdata <= {14'h0, mr6_r};
				MRPD_REG_CTRL: reg_rdata <= {27'h0, odt_r, pd_r, badpar_r, 2'h0};
				MRPD_REG_STAT: reg_rdata <= {28'h0, state_r != MRPD_ST_IDLE,
					pend6_r || pend5_r, refused_r, 1'b0};
				default: reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

endmodule : mrpd_ctrl

// [verification/mrpd_asserts.sv]
// checker on the command pins between controller and device
`timescale 1ns/1ps
module mrpd_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic act_n,
	input wire logic cke,
	input wire logic odt,
	input wire logic par,
	input wire logic [1:0] bg,
	input wire logic [1:0] ba,
	input wire logic [17:0] a
);
	import mrpd_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	wire s5 = !cs_n && {bg[0], ba} == MRPD_SEL_MR5;
	wire s6 = !cs_n && {bg[0], ba} == MRPD_SEL_MR6;

	a_mrs_strobes_low: assert property (!cs_n |-> a[16:14] == 3'h0 && act_n)
		else $error("mode write without low strobes");
	a_reg_select: assert property (!cs_n |-> (s5 || s6) && !bg[1])
		else $error("mode write to unexpected register");
	a_mr6_rsvd_zero: assert property (s6 |-> (a & MRPD_MR6_RSVD) == 18'h0)
		else $error("reserved sixth register bits sent nonzero");
	a_mr6_ccd_legal: assert property (s6 |-> a[12:10] <= MRPD_CCD_MAX)
		else $error("reserved column spacing code sent");
	a_inv_mask_excl: assert property (s5 |-> !(a[11] && a[10]))
		else $error("write inversion sent with byte mask");
	a_mr5_lat_legal: assert property (s5 |-> a[2:0] <= MRPD_LAT_MAX)
		else $error("reserved parity latency sent");
	// one command per slot keeps the device pipe from overlapping
	a_cmd_gap_held: assert property (!cs_n |=> cs_n [*8])
		else $error("commands too close together");
	a_pd_no_cmd: assert property (!cke |-> cs_n)
		else $error("command issued in power-down");

	cover property (s5 && a[2:0] != 3'h0);
	cover property (s6 && a[7]);
	cover property (!cke && odt);
endmodule : mrpd_asserts

// [verification/test_mode_reg_parity_dbi_config.sv]
// self-checking bench joining the controller and device ends
`timescale 1ns/1ps
module test_mode_reg_parity_dbi_config;
	import mrpd_pkg::*;
	logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, rd_seen = 0, snap = 0, drop_s;
	logic stacked_die_variant = 0, mpr_read = 0, crc_fail = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'hcf871c47;
	mrpd_org_e org = MRPD_ORG_X4;
	logic cmd_exec, cmd_dropped, par_err, crc_err, rd_inv_on, wr_inv_on, wr_mask_on;
	logic nom_term_on, vref_cal_en, vref_range;
	logic [2:0] park_term_code;
	logic [3:0] cas_spacing;
	logic [5:0] vref_level;
	logic [12:0] m5 = 13'h0;
	logic [17:0] m6 = 18'h0;
	bit pe, ce, odt_l, pd_l;
	logic [31:0] q_rd[$];
	logic [21:0] q_st[$];
	int fails = 0, n_tests = 0;

	mrpd_if link();
	mrpd_ctrl mrpd_ctrl_i (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.stacked_die_variant(stacked_die_variant), .bus(link));
	mrpd_dram mrpd_dram_i (.clk(clk), .reset(reset), .bus(link), .org(org), .mpr_read(mpr_read),
		.crc_fail(crc_fail), .cmd_exec(cmd_exec), .cmd_dropped(cmd_dropped), .par_err(par_err),
		.crc_err(crc_err), .rd_inv_on(rd_inv_on), .wr_inv_on(wr_inv_on), .wr_mask_on(wr_mask_on),
		.nom_term_on(nom_term_on), .park_term_code(park_term_code), .cas_spacing(cas_spacing),
		.vref_cal_en(vref_cal_en), .vref_range(vref_range), .vref_level(vref_level));
	mrpd_asserts mrpd_asserts_i (.clk(clk), .reset(reset), .cs_n(link.cs_n), .act_n(link.act_n),
		.cke(link.cke), .odt(link.odt), .par(link.par), .bg(link.bg), .ba(link.ba), .a(link.a));

	initial begin
		forever #10 clk = ~clk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// expected device outputs from the settings sent so far
	function automatic logic [21:0] vexp(input logic drop);
		logic on;
		on = org != MRPD_ORG_X4;
		return {drop, pe, ce, m5[12] & on & !mpr_read, m5[11] & on, m5[10] & on,
			odt_l & !(pd_l & m5[5]), m5[8:6], 4'h4 + {1'b0, m6[12:10]}, m6[7:0]};
	endfunction : vexp

	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_rd

	task automatic chk_st(input logic [21:0] got, input logic [21:0] exp);
		chk_rd({10'h0, got}, {10'h0, exp});
	endtask : chk_st

	always @(posedge clk) rd_seen <= reg_rd;
	always @(negedge clk) begin
		if (rd_seen)
			chk_rd(reg_rdata, q_rd.pop_front());
	end
	// device outputs settle one cycle after the command pulse
	always @(negedge clk) begin
		if (cmd_exec | cmd_dropped | snap) begin
			drop_s = cmd_dropped;
			repeat (2) @(negedge clk);
			chk_st({drop_s, par_err, crc_err, rd_inv_on, wr_inv_on, wr_mask_on, nom_term_on,
				park_term_code, cas_spacing, vref_cal_en, vref_range, vref_level}, q_st.pop_front());
		end
	end

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		q_rd.push_back(e);
		@(posedge clk);
		reg_addr <= ad;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
	endtask : rd

	task automatic go(input bit six, input logic [17:0] v, input bit bad);
		bit drop;
		int k;
		drop = bad && m5[2:0] != 3'h0 && (m5[9] || !pe);
		if (drop)
			pe = 1;
		else if (six)
			m6 = v;
		else begin
			m5 = v[12:0] & ~{stacked_die_variant, stacked_die_variant, 11'h0};
			if (!v[4])
				pe = 0;
			if (!v[3])
				ce = 0;
		end
		q_st.push_back(vexp(drop));
		wr(six ? MRPD_REG_MR6 : MRPD_REG_MR5, {14'h0, v});
		wr(MRPD_REG_CTRL, {27'h0, odt_l, 1'b0, bad, six, !six});
		for (k = 0; k < 40 && !(cmd_exec | cmd_dropped); k++) @(negedge clk);
		if (k == 40)
			fails++;
		repeat (12) @(posedge clk);
	endtask : go

	task automatic look();
		q_st.push_back(vexp(0));
		repeat (3) @(posedge clk);
		snap <= 1;
		@(posedge clk);
		snap <= 0;
	endtask : look

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_of_test();
	end

	initial begin
		repeat (4) @(posedge clk);
		reset <= 0;
		rd(MRPD_REG_MR5, 32'h0);
		rd(MRPD_REG_MR6, 32'h0);
		rd(MRPD_REG_STAT, 32'h0);
		rd(8'h10, 32'h0);
		for (int o = 0; o < 3; o++) begin
			org <= mrpd_org_e'(o);
			mpr_read <= o == 2;
			@(posedge clk);
			go(0, 18'h1800, 0);
			go(0, 18'h15c0, 0);
		end
		// illegal settings are refused and leave the shadow untouched
		for (int i = 0; i < 3; i++) begin
			wr(i == 2 ? MRPD_REG_MR6 : MRPD_REG_MR5, i == 0 ? 32'hc00 : i == 1 ? 32'h4 : 32'h1400);
			rd(MRPD_REG_STAT, 32'h2);
			wr(MRPD_REG_STAT, 32'h2);
			rd(i == 2 ? MRPD_REG_MR6 : MRPD_REG_MR5, i == 2 ? {14'h0, m6} : {19'h0, m5});
		end
		rd(MRPD_REG_STAT, 32'h0);
		for (int c = 0; c < 5; c++) go(1, {5'h0, 3'(c), 2'h0, 8'(xs())}, 0);
		rd(MRPD_REG_MR6, {14'h0, m6});
		for (int l = 1; l < 4; l++) begin
			go(0, 18'(l), 0);
			go(0, 18'(l), 1);
			go(0, 18'(l) | 18'h10, 1);
			go(0, 18'(l) | 18'h210, 1);
			go(0, 18'(l) | 18'h210, 1);
			go(0, 18'(l), 0);
		end
		go(0, 18'h0, 1);
		crc_fail <= 1;
		@(posedge clk);
		crc_fail <= 0;
		ce = 1;
		go(0, 18'h8, 0);
		go(0, 18'h0, 0);
		stacked_die_variant <= 1;
		@(posedge clk);
		go(0, 18'h1800, 0);
		rd(MRPD_REG_MR5, 32'h0);
		stacked_die_variant <= 0;
		go(0, 18'h20, 0);
		odt_l = 1;
		pd_l = 1;
		wr(MRPD_REG_CTRL, 32'h18);
		look();
		pd_l = 0;
		go(0, 18'h0, 0);
		pd_l = 1;
		wr(MRPD_REG_CTRL, 32'h18);
		look();
		rd(MRPD_REG_CTRL, 32'h18);
		repeat (5) @(posedge clk);
		end_of_test();
	end
endmodule : test_mode_reg_parity_dbi_config
